//--- hdl/eeprom_target.sv
// Two-wire serial memory target: select decode, address decode, write buffering and write cycle
`timescale 1ns/1ps

module eeprom_target #(
	parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES, // Internal write duration in core cycles
	parameter logic [3:0] ARRAY_TYPE_ID = 4'h5, // Arbitrary value, array type identifier
	parameter logic [3:0] FEATURE_TYPE_ID = 4'h6 // Arbitrary value, feature type identifier
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic write_protect_input,
	output logic wr_valid,
	output eeprom_pkg::wr_req_t wr_req,
	output logic busy,
	output logic [eeprom_pkg::ADDR_W-1:0] addr_counter,
	output eeprom_pkg::select_cfg_t configurable_select_register,
	output logic id_locked
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	localparam int CNT_W = $clog2(WRITE_CYCLES + 1); // Write timer width
	localparam int N_SYNC = 4; // scl, sda, protect, byte toggle

	eeprom_pkg::state_t state_r; // Transfer phase
	eeprom_pkg::state_t state_after; // Phase after the current ack slot
	eeprom_pkg::target_t target_r; // What the address bytes selected
	logic [N_SYNC-1:0] sync1_r; // First synchroniser stage
	logic [N_SYNC-1:0] sync2_r; // Second synchroniser stage
	logic [N_SYNC-1:0] sync_d_r; // Previous synchronised value
	logic [N_SYNC-1:0] async_in; // Raw inputs from other domains
	logic scl_s, sda_s, wp_s; // Synchronised pins
	logic start, stop, scl_fall, byte_rdy; // Bus events
	logic [7:0] shift_q; // Byte from the sampler
	logic byte_tog; // Sampler byte toggle
	logic link_clr_r; // Holds the sampler cleared
	logic link_clr; // Sampler clear including reset
	logic ack_pend_r; // Byte taken, ack slot not begun
	logic in_ack_r; // Inside the ninth slot
	logic ack_want_r; // Decision for this ack slot
	logic ack_dec; // Decision from the byte just received
	logic sda_oe_r; // Pull-down of the data line
	logic fresh_r; // Stop now would fall in the tenth slot
	logic sel_match; // Select byte addresses this device
	logic dir_read; // Select byte asks for a read
	logic commit_ok; // Stop starts a write cycle
	logic [6:0] hi_r; // Array address bits 14..8
	logic [1:0] lo_top_r; // Array address bits 7..6
	logic [eeprom_pkg::OFF_W-1:0] off_r; // In-page offset
	logic [6:0] data_cnt_r; // Data bytes received, acked or not, saturating
	logic lock_bit_r; // Lock byte carried its key bit
	logic [7:0] cfg_data_r; // Last data byte for the select register
	logic [7:0] page_buf [eeprom_pkg::PAGE_BYTES]; // Latched page data
	logic [eeprom_pkg::PAGE_BYTES-1:0] buf_valid_r; // Offsets written this frame
	logic [CNT_W-1:0] tw_cnt_r; // Write cycle timer
	logic busy_done; // Last cycle of the write cycle
	logic [eeprom_pkg::OFF_W-1:0] walk_idx; // Buffer entry emitted now
	logic cfg_lock_r; // Select register lock bit
	logic [2:0] cfg_ce_r; // Select register chip-enable bits
	logic id_locked_r; // Identification page frozen
	logic [eeprom_pkg::ADDR_W-1:0] addr_cnt_r; // Internal address counter
	eeprom_pkg::wr_req_t wr_req_r; // Registered write request
	logic wr_valid_r; // Registered write strobe

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	assign async_in = {byte_tog, write_protect_input, sda_in, scl};

	// Two stages per input; the edge detectors only look at stage two
	genvar gi;
	generate
		for (gi = 0; gi < N_SYNC; gi++) begin : g_sync
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					sync1_r[gi] <= 1'b0;
					sync2_r[gi] <= 1'b0;
					sync_d_r[gi] <= 1'b0;
				end else begin
					sync1_r[gi] <= async_in[gi];
					sync2_r[gi] <= sync1_r[gi];
					sync_d_r[gi] <= sync2_r[gi];
				end
			end
		end
	endgenerate

	assign scl_s = sync2_r[0];
	assign sda_s = sync2_r[1];
	assign wp_s = sync2_r[2];

	// Line conditions are only meaningful with the clock held high
	assign start = scl_s && sync_d_r[0] && sync_d_r[1] && !sda_s;
	assign stop = scl_s && sync_d_r[0] && !sync_d_r[1] && sda_s;
	assign scl_fall = !scl_s && sync_d_r[0];
	assign byte_rdy = sync2_r[3] ^ sync_d_r[3];

	// ----------------------------------------------------------------
	// Link-side sampler
	// ----------------------------------------------------------------
	assign link_clr = rst | link_clr_r;

	link_sampler u_sampler (
		.scl(scl),
		.rst(rst),
		.clr(link_clr),
		.sda_in(sda_in),
		.shift_q(shift_q),
		.byte_tog(byte_tog)
	);

	// Sampler held cleared outside frames and during the write cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			link_clr_r <= 1'b1;
		end else begin
			link_clr_r <= start || state_r == eeprom_pkg::ST_IDLE || state_r == eeprom_pkg::ST_BUSY;
		end
	end

	// ----------------------------------------------------------------
	// Byte decode
	// ----------------------------------------------------------------
	// Chip-enable match against the stored register, type must be known
	assign sel_match = shift_q[eeprom_pkg::SEL_CE_LSB +: 3] == cfg_ce_r &&
		(shift_q[eeprom_pkg::SEL_TYPE_LSB +: 4] == ARRAY_TYPE_ID ||
		shift_q[eeprom_pkg::SEL_TYPE_LSB +: 4] == FEATURE_TYPE_ID);
	assign dir_read = shift_q[eeprom_pkg::SEL_DIR_BIT];

	// Acknowledge decision for the byte just completed
	always_comb begin
		ack_dec = 1'b0;
		unique case (state_r)
			eeprom_pkg::ST_SEL: ack_dec = sel_match;
			eeprom_pkg::ST_ADDR_HI, eeprom_pkg::ST_ADDR_LO: ack_dec = 1'b1;
			eeprom_pkg::ST_DATA: begin
				unique case (target_r)
					eeprom_pkg::TGT_ARRAY: ack_dec = !wp_s;
					eeprom_pkg::TGT_ID, eeprom_pkg::TGT_LOCK: ack_dec = !wp_s && !id_locked_r;
					eeprom_pkg::TGT_CFG: ack_dec = !wp_s && !cfg_lock_r;
				endcase
			end
			eeprom_pkg::ST_IDLE, eeprom_pkg::ST_BUSY: ack_dec = 1'b0;
		endcase
	end

	// Phase reached when the ack slot closes
	always_comb begin
		state_after = eeprom_pkg::ST_IDLE;
		unique case (state_r)
			// Reads are not served here, so a read request drops to standby after its ack
			eeprom_pkg::ST_SEL: state_after = (ack_want_r && !dir_read) ? eeprom_pkg::ST_ADDR_HI : eeprom_pkg::ST_IDLE;
			eeprom_pkg::ST_ADDR_HI: state_after = eeprom_pkg::ST_ADDR_LO;
			eeprom_pkg::ST_ADDR_LO: state_after = eeprom_pkg::ST_DATA;
			eeprom_pkg::ST_DATA: state_after = eeprom_pkg::ST_DATA;
			eeprom_pkg::ST_IDLE, eeprom_pkg::ST_BUSY: state_after = eeprom_pkg::ST_IDLE;
		endcase
	end

	// Whether a stop seen now may start the write cycle
	always_comb begin
		commit_ok = 1'b0;
		if (fresh_r && state_r == eeprom_pkg::ST_DATA) begin
			unique case (target_r)
				eeprom_pkg::TGT_ARRAY, eeprom_pkg::TGT_ID: commit_ok = 1'b1;
				eeprom_pkg::TGT_LOCK: commit_ok = lock_bit_r;
				// More than one byte aborts a select register write
				eeprom_pkg::TGT_CFG: commit_ok = data_cnt_r == 7'h01;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Protocol sequencer
	// ----------------------------------------------------------------
	// Write cycle ignores the bus entirely; start wins over any other event
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= eeprom_pkg::ST_IDLE;
			ack_pend_r <= 1'b0;
			in_ack_r <= 1'b0;
			ack_want_r <= 1'b0;
			sda_oe_r <= 1'b0;
			fresh_r <= 1'b0;
		end else if (state_r == eeprom_pkg::ST_BUSY) begin
			sda_oe_r <= 1'b0;
			if (busy_done) begin
				state_r <= eeprom_pkg::ST_IDLE;
			end
		end else if (start) begin
			state_r <= eeprom_pkg::ST_SEL;
			ack_pend_r <= 1'b0;
			in_ack_r <= 1'b0;
			sda_oe_r <= 1'b0;
			fresh_r <= 1'b0;
		end else if (stop) begin
			state_r <= commit_ok ? eeprom_pkg::ST_BUSY : eeprom_pkg::ST_IDLE;
			ack_pend_r <= 1'b0;
			in_ack_r <= 1'b0;
			sda_oe_r <= 1'b0;
			fresh_r <= 1'b0;
		end else begin
			// The stop itself raises the clock, so only a falling clock ends the tenth slot
			if (scl_fall) begin
				fresh_r <= 1'b0;
			end
			if (byte_rdy && state_r != eeprom_pkg::ST_IDLE) begin
				ack_pend_r <= 1'b1;
				ack_want_r <= ack_dec;
			end else if (scl_fall && ack_pend_r) begin
				// Drive only after the clock is low, keeping data stable on the high phase
				ack_pend_r <= 1'b0;
				in_ack_r <= 1'b1;
				sda_oe_r <= ack_want_r;
			end else if (scl_fall && in_ack_r) begin
				in_ack_r <= 1'b0;
				sda_oe_r <= 1'b0;
				state_r <= state_after;
				fresh_r <= state_r == eeprom_pkg::ST_DATA && ack_want_r;
			end
		end
	end

	assign sda_oe = sda_oe_r;
	assign sda_out = 1'b0; // Open drain: only ever pulls low

	// ----------------------------------------------------------------
	// Address and data capture
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			target_r <= eeprom_pkg::TGT_ARRAY;
			hi_r <= 7'h00;
			lo_top_r <= 2'h0;
			off_r <= '0;
			data_cnt_r <= 7'h00;
			lock_bit_r <= 1'b0;
			cfg_data_r <= 8'h00;
		end else if (byte_rdy && state_r != eeprom_pkg::ST_BUSY) begin
			unique case (state_r)
				eeprom_pkg::ST_SEL: begin
					// Array versus feature space is fixed by the type field
					target_r <= (shift_q[eeprom_pkg::SEL_TYPE_LSB +: 4] == ARRAY_TYPE_ID) ?
						eeprom_pkg::TGT_ARRAY : eeprom_pkg::TGT_ID;
				end
				eeprom_pkg::ST_ADDR_HI: begin
					hi_r <= shift_q[6:0];
					if (target_r != eeprom_pkg::TGT_ARRAY) begin
						if (shift_q[7:eeprom_pkg::HI_FEAT_LSB] == eeprom_pkg::HI_CFG_CODE) begin
							target_r <= eeprom_pkg::TGT_CFG;
						end else if (shift_q[eeprom_pkg::HI_LOCK_BIT]) begin
							target_r <= eeprom_pkg::TGT_LOCK;
						end else begin
							target_r <= eeprom_pkg::TGT_ID;
						end
					end
				end
				eeprom_pkg::ST_ADDR_LO: begin
					lo_top_r <= shift_q[7:6];
					off_r <= shift_q[eeprom_pkg::OFF_W-1:0];
					data_cnt_r <= 7'h00;
					lock_bit_r <= 1'b0;
				end
				eeprom_pkg::ST_DATA: begin
					off_r <= off_r + 6'h01;
					if (data_cnt_r != 7'h7f) begin
						data_cnt_r <= data_cnt_r + 7'h01;
					end
					lock_bit_r <= shift_q[eeprom_pkg::LOCK_DATA_BIT];
					cfg_data_r <= shift_q;
				end
				eeprom_pkg::ST_IDLE, eeprom_pkg::ST_BUSY: begin
					lock_bit_r <= lock_bit_r;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Page buffer
	// ----------------------------------------------------------------
	// Storage needs no reset; validity bits say what is real
	always_ff @(posedge clk) begin
		if (byte_rdy && state_r == eeprom_pkg::ST_DATA && ack_dec) begin
			page_buf[off_r] <= shift_q;
		end
	end

	// Validity cleared by each start outside the write cycle so an aborted frame leaves nothing behind
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			buf_valid_r <= '0;
		end else if (start && state_r != eeprom_pkg::ST_BUSY) begin
			buf_valid_r <= '0;
		end else if (byte_rdy && state_r == eeprom_pkg::ST_DATA && ack_dec) begin
			buf_valid_r[off_r] <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Internal write cycle
	// ----------------------------------------------------------------
	assign busy_done = state_r == eeprom_pkg::ST_BUSY && tw_cnt_r == CNT_W'(WRITE_CYCLES - 1);
	assign walk_idx = tw_cnt_r[eeprom_pkg::OFF_W-1:0];
	assign busy = state_r == eeprom_pkg::ST_BUSY;

	// Timer runs from the stop until the programmed count expires
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tw_cnt_r <= '0;
		end else if (state_r == eeprom_pkg::ST_BUSY) begin
			tw_cnt_r <= tw_cnt_r + CNT_W'(1);
		end else begin
			tw_cnt_r <= '0;
		end
	end

	// Buffered bytes leave one per cycle at the start of the write cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_valid_r <= 1'b0;
			wr_req_r <= '0;
		end else if (state_r == eeprom_pkg::ST_BUSY) begin
			wr_req_r.target <= target_r;
			unique case (target_r)
				eeprom_pkg::TGT_ARRAY: begin
					wr_valid_r <= tw_cnt_r < CNT_W'(eeprom_pkg::PAGE_BYTES) && buf_valid_r[walk_idx];
					wr_req_r.addr <= {hi_r, lo_top_r, walk_idx};
					wr_req_r.data <= page_buf[walk_idx];
				end
				eeprom_pkg::TGT_ID: begin
					wr_valid_r <= tw_cnt_r < CNT_W'(eeprom_pkg::PAGE_BYTES) && buf_valid_r[walk_idx];
					wr_req_r.addr <= {{eeprom_pkg::PAGE_W{1'b0}}, walk_idx};
					wr_req_r.data <= page_buf[walk_idx];
				end
				eeprom_pkg::TGT_LOCK, eeprom_pkg::TGT_CFG: begin
					wr_valid_r <= tw_cnt_r == '0;
					wr_req_r.addr <= '0;
					wr_req_r.data <= cfg_data_r;
				end
			endcase
		end else begin
			wr_valid_r <= 1'b0;
		end
	end

	assign wr_valid = wr_valid_r;
	assign wr_req = wr_req_r;

	// ----------------------------------------------------------------
	// Persistent state updated at the end of the write cycle
	// ----------------------------------------------------------------
	// New chip-enable bits only take effect once the cycle completes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_ce_r <= eeprom_pkg::CFG_RESET[eeprom_pkg::CFG_CE_LSB +: 3];
			cfg_lock_r <= eeprom_pkg::CFG_RESET[eeprom_pkg::CFG_LOCK_BIT];
			id_locked_r <= 1'b0;
			addr_cnt_r <= '0;
		end else if (busy_done) begin
			unique case (target_r)
				eeprom_pkg::TGT_ARRAY: addr_cnt_r <= {hi_r, lo_top_r, off_r};
				eeprom_pkg::TGT_ID: addr_cnt_r <= addr_cnt_r;
				eeprom_pkg::TGT_LOCK: id_locked_r <= 1'b1;
				eeprom_pkg::TGT_CFG: begin
					cfg_ce_r <= cfg_data_r[eeprom_pkg::CFG_CE_LSB +: 3];
					cfg_lock_r <= cfg_data_r[eeprom_pkg::CFG_LOCK_BIT];
				end
			endcase
		end
	end

	assign configurable_select_register = '{chip_enable: cfg_ce_r, lock: cfg_lock_r};
	assign id_locked = id_locked_r;
	assign addr_counter = addr_cnt_r;

endmodule : eeprom_target

//--- hdl/eeprom_pkg.sv
// Shared constants, field positions and carrier types of the serial memory target front end
package eeprom_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20; // Core clock period, 50 MHz
	localparam int T_WRITE_NS = 5000000; // Longest internal write cycle, 5 ms
	localparam int WRITE_CYCLES = T_WRITE_NS / CLK_PERIOD_NS; // Longest time rounds down

	// ----------------------------------------------------------------
	// Geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W = 15; // Array byte address width
	localparam int OFF_W = 6; // In-page offset width
	localparam int PAGE_W = ADDR_W - OFF_W; // Page number width
	localparam int PAGE_BYTES = 64; // Bytes per page and in the identification page
	localparam int BYTE_BITS = 8; // Bits per byte before the acknowledge slot

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int SEL_DIR_BIT = 0; // Direction bit of the select byte
	localparam int SEL_CE_LSB = 1; // Chip-enable field, bits 3..1
	localparam int SEL_TYPE_LSB = 4; // Type identifier, bits 7..4
	localparam int HI_FEAT_LSB = 5; // First address byte, bits 7..5 pick the select register
	localparam int HI_LOCK_BIT = 2; // First address byte, page lock versus identification page
	localparam int LOCK_DATA_BIT = 1; // Lock byte must carry a one here
	localparam int CFG_LOCK_BIT = 0; // Lock bit of the select register
	localparam int CFG_CE_LSB = 1; // Chip-enable bits of the select register
	localparam logic [2:0] HI_CFG_CODE = 3'h6; // Upper bits that address the select register

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] CFG_RESET = 8'h00; // Select register after power-on

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {TGT_ARRAY, TGT_ID, TGT_LOCK, TGT_CFG} target_t;

	typedef enum {ST_IDLE, ST_SEL, ST_ADDR_HI, ST_ADDR_LO, ST_DATA, ST_BUSY} state_t;

	// One committed byte handed to the storage behind the block
	typedef struct packed {
		target_t target;
		logic [ADDR_W-1:0] addr;
		logic [7:0] data;
	} wr_req_t;

	// Live contents of the configurable select register
	typedef struct packed {
		logic [2:0] chip_enable;
		logic lock;
	} select_cfg_t;

endpackage : eeprom_pkg

//--- hdl/link_sampler.sv
// Bit sampler clocked by the serial clock: shifts data in and flags each full byte
`timescale 1ns/1ps

module link_sampler (
	input wire logic scl,
	input wire logic rst,
	input wire logic clr,
	input wire logic sda_in,
	output logic [7:0] shift_q,
	output logic byte_tog
);

	// ----------------------------------------------------------------
	// Slot counting
	// ----------------------------------------------------------------
	logic [3:0] slot_r; // 0..7 data bits, 8 acknowledge slot

	// Sample on the rising edge, most significant bit first; the ack slot is not shifted
	always_ff @(posedge scl or posedge clr) begin
		if (clr) begin
			slot_r <= 4'h0;
			shift_q <= 8'h00;
		end else if (slot_r == 4'(eeprom_pkg::BYTE_BITS)) begin
			slot_r <= 4'h0;
		end else begin
			shift_q <= {shift_q[6:0], sda_in};
			slot_r <= slot_r + 4'h1;
		end
	end

	// ----------------------------------------------------------------
	// Byte event
	// ----------------------------------------------------------------
	// Toggle survives the frame clear so the core never sees a false event
	always_ff @(posedge scl or posedge rst) begin
		if (rst) begin
			byte_tog <= 1'b0;
		end else if (!clr && slot_r == 4'(eeprom_pkg::BYTE_BITS - 1)) begin
			byte_tog <= ~byte_tog;
		end
	end

endmodule : link_sampler

//--- test/eeprom_target_asserts.sv
// Port-level checker for the serial memory target
`timescale 1ns/1ps
module eeprom_target_asserts #(
	parameter int WRITE_CYCLES = 100 // Write cycle length in core cycles
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic scl,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic write_protect_input,
	input wire logic wr_valid,
	input wire eeprom_pkg::wr_req_t wr_req,
	input wire logic busy,
	input wire logic [eeprom_pkg::ADDR_W-1:0] addr_counter,
	input wire eeprom_pkg::select_cfg_t configurable_select_register,
	input wire logic id_locked
);
	// ----------------------------------------------------------------
	// Helper state
	// ----------------------------------------------------------------
	int busy_cnt_r; // Busy cycles so far
	logic prev_v_r; // A byte was emitted in this write cycle
	logic [eeprom_pkg::ADDR_W-1:0] prev_addr_r; // Address of that byte
	// Count busy cycles, cleared when idle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy_cnt_r <= 0;
		end else begin
			busy_cnt_r <= busy ? busy_cnt_r + 1 : 0;
		end
	end
	// Remember the last emitted address, forgotten between write cycles
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prev_v_r <= 1'b0;
			prev_addr_r <= '0;
		end else begin
			prev_v_r <= busy && (prev_v_r || wr_valid);
			prev_addr_r <= wr_valid ? wr_req.addr : prev_addr_r;
		end
	end
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking dflt_cb @(posedge clk);
	endclocking
	default disable iff (rst);
	a_pull_zero: assert property (sda_out == 1'b0) else $error("pull value not zero");
	a_ack_stands: assert property ($rose(sda_oe) |-> sda_oe [*3]) else $error("ack too short");
	a_busy_quiet: assert property (busy |-> !sda_oe) else $error("drives data while busy");
	a_busy_len: assert property ($fell(busy) |-> busy_cnt_r == WRITE_CYCLES) else $error("busy length");
	a_emit_busy: assert property (wr_valid |-> busy) else $error("commit outside write cycle");
	a_busy_idle: assert property ($rose(busy) |-> scl && sda_in) else $error("write without stop");
	a_page_stays: assert property (wr_valid && prev_v_r && wr_req.target == eeprom_pkg::TGT_ARRAY
		|-> wr_req.addr[14:6] == prev_addr_r[14:6] && wr_req.addr[5:0] > prev_addr_r[5:0])
		else $error("commit leaves page");
	a_counter_end: assert property ($changed(addr_counter)
		|-> !busy && ($past(busy) || $past(busy, 2))) else $error("counter moved mid-cycle");
	a_select_end: assert property ($changed(configurable_select_register)
		|-> !busy && ($past(busy) || $past(busy, 2))) else $error("select register moved mid-cycle");
	c_commit: cover property (wr_valid);
	c_cycle_end: cover property ($fell(busy));
	c_ack_protected: cover property ($rose(sda_oe) && write_protect_input);
endmodule : eeprom_target_asserts

//--- test/i2c_controller_model.sv
// Bus controller model: drives the serial clock and pulls the data wire
`timescale 1ns/1ps
module i2c_controller_model (
	output logic scl,
	output logic ctl_oe,
	input wire logic sda
);
	// Clock stands high and data is released between frames
	initial begin
		scl = 1'b1;
		ctl_oe = 1'b0;
	end
	// Data falls while the clock is high
	task start;
		ctl_oe = 1'b0;
		#20 ctl_oe = 1'b1;
		#40 scl = 1'b0;
		#43; // Room for the target to open its sampler before the first rise
	endtask : start
	// Eight bits then the ack slot; returns true when pulled low
	task send_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			ctl_oe = !b[i];
			#17 scl = 1'b1;
			#40 scl = 1'b0;
			#23;
		end
		ctl_oe = 1'b0;
		#57 scl = 1'b1; // Longer low lets the target pull before the rise
		#38 ack = !sda;
		#2 scl = 1'b0;
		#63; // Longer low lets the target let go of its ack
	endtask : send_byte
	// Data rises while the clock is high, straight after an ack slot
	task stop;
		ctl_oe = 1'b1;
		#17 scl = 1'b1;
		#40 ctl_oe = 1'b0;
		#40;
	endtask : stop
endmodule : i2c_controller_model

//--- test/eeprom_target_test.sv
// Self-checking bench for the serial memory target
`timescale 1ns/1ps
module eeprom_target_test;
	localparam int WCYC = 100; // Short write cycle
	localparam logic [3:0] ARR = 4'h5; // Arbitrary value, array type id
	localparam logic [3:0] FEAT = 4'h6; // Arbitrary value, feature type id
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wp = 1'b0; // Write protect level
	wire scl;
	wire ctl_oe;
	wire sda; // Resolved open-drain wire
	logic sda_out, sda_oe, wr_valid, busy, id_locked;
	eeprom_pkg::wr_req_t wr_req;
	logic [eeprom_pkg::ADDR_W-1:0] addr_counter;
	eeprom_pkg::select_cfg_t cfg;
	eeprom_pkg::wr_req_t seen[$]; // Committed bytes in order
	eeprom_pkg::wr_req_t exp_w [3] = '{{eeprom_pkg::TGT_ARRAY, 15'h0100, 8'ha3},
		{eeprom_pkg::TGT_ARRAY, 15'h013e, 8'ha1}, {eeprom_pkg::TGT_ARRAY, 15'h013f, 8'ha2}};
	int errors = 0;
	int checks_done = 0;
	always #10 clk = ~clk;
	// Pull-up unless someone pulls low
	assign sda = ((sda_oe && !sda_out) || ctl_oe) ? 1'b0 : 1'b1;
	// Collect every commit
	always @(posedge clk) begin
		if (wr_valid === 1'b1) seen.push_back(wr_req);
	end
	eeprom_target #(.WRITE_CYCLES(WCYC), .ARRAY_TYPE_ID(ARR), .FEATURE_TYPE_ID(FEAT)) eeprom_target_i (
		.clk(clk), .rst(rst), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.write_protect_input(wp), .wr_valid(wr_valid), .wr_req(wr_req), .busy(busy),
		.addr_counter(addr_counter), .configurable_select_register(cfg), .id_locked(id_locked));
	i2c_controller_model i2c_controller_model_i (.scl(scl), .ctl_oe(ctl_oe), .sda(sda));
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task check(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask : check
	task xfer(input logic [7:0] b, input logic exp_ack, input string msg);
		logic ack;
		i2c_controller_model_i.send_byte(b, ack);
		check(ack, exp_ack, msg);
	endtask : xfer
	// Start, write select and both address bytes, all acked
	task head(input logic [7:0] sel, input logic [7:0] hi, input logic [7:0] lo);
		i2c_controller_model_i.start();
		xfer(sel, 1'b1, "select");
		xfer(hi, 1'b1, "address high");
		xfer(lo, 1'b1, "address low");
	endtask : head
	// Bounded wait for the write cycle to end
	task settle;
		repeat (10) @(posedge clk);
		for (int i = 0; i < WCYC + 20 && busy !== 1'b0; i++) @(posedge clk);
		check(busy, 1'b0, "write cycle end");
	endtask : settle
	// Single select frame with an expected answer
	task poll(input logic [7:0] sel, input logic exp_ack, input string msg);
		i2c_controller_model_i.start();
		xfer(sel, exp_ack, msg);
		i2c_controller_model_i.stop();
	endtask : poll
	task summarize;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : summarize
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clk);
		#2 rst = 1'b0;
		repeat (4) @(posedge clk);
		check({busy, sda_oe, id_locked, cfg, addr_counter}, 32'h0, "reset state");
		$display("test reset done");
		// Page write from offset 3e rolls over to offset 0
		head({ARR, 3'h0, 1'b0}, 8'h81, 8'h3e);
		xfer(8'ha1, 1'b1, "data 0");
		xfer(8'ha2, 1'b1, "data 1");
		xfer(8'ha3, 1'b1, "data 2");
		i2c_controller_model_i.stop();
		repeat (10) @(posedge clk);
		check(busy, 1'b1, "write cycle running");
		poll({ARR, 3'h0, 1'b0}, 1'b0, "select while busy");
		settle();
		check(seen.size(), 3, "commit count");
		foreach (exp_w[i]) check(seen[i], exp_w[i], "commit");
		check(addr_counter, 15'h0101, "counter after write");
		poll({ARR, 3'h0, 1'b1}, 1'b1, "read select");
		$display("test page write done");
		// Protected data refused; stop after address discards
		seen.delete();
		@(posedge clk);
		#2 wp = 1'b1;
		head({ARR, 3'h0, 1'b0}, 8'h02, 8'h10);
		xfer(8'h55, 1'b0, "protected data");
		i2c_controller_model_i.stop();
		@(posedge clk);
		#2 wp = 1'b0;
		head({ARR, 3'h0, 1'b0}, 8'h02, 8'h10);
		i2c_controller_model_i.stop();
		repeat (10) @(posedge clk);
		check(busy, 1'b0, "no write cycle");
		check(seen.size(), 0, "nothing written");
		$display("test refusals done");
		// New chip-enable bits through the select register
		poll({ARR, 3'h2, 1'b0}, 1'b0, "foreign select");
		head({FEAT, 3'h0, 1'b0}, 8'hc0, 8'h00);
		xfer(8'h06, 1'b1, "select register data");
		i2c_controller_model_i.stop();
		settle();
		check(cfg, {3'h3, 1'b0}, "select register");
		check(addr_counter, 15'h0101, "counter kept");
		poll({ARR, 3'h3, 1'b0}, 1'b1, "new address");
		poll({ARR, 3'h0, 1'b0}, 1'b0, "old address");
		// Lock the identification page, then its data is refused
		head({FEAT, 3'h3, 1'b0}, 8'h04, 8'h00);
		xfer(8'h02, 1'b1, "lock data");
		i2c_controller_model_i.stop();
		settle();
		check(id_locked, 1'b1, "page locked");
		head({FEAT, 3'h3, 1'b0}, 8'h00, 8'h05);
		xfer(8'h11, 1'b0, "locked page data");
		i2c_controller_model_i.stop();
		$display("test select register done");
		summarize();
	end
	// Watchdog
	initial begin
		#400000;
		errors++;
		summarize();
	end
endmodule : eeprom_target_test
bind eeprom_target eeprom_target_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) eeprom_target_asserts_i (
	.clk(clk), .rst(rst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
	.write_protect_input(write_protect_input), .wr_valid(wr_valid), .wr_req(wr_req), .busy(busy),
	.addr_counter(addr_counter), .configurable_select_register(configurable_select_register),
	.id_locked(id_locked));
